// ---- rtl/operand_decode.sv ----
// Operand decoder with cycle count and status flag storage.
`timescale 1ns/100ps
`default_nettype none
module operand_decode (
  input wire logic mclk,
  input wire logic reset_n,
  input wire opdec_pkg::instr_req_t req,
  input wire logic mcu_flag_we,
  input wire opdec_pkg::mcu_flags_t mcu_flag_in,
  input wire logic dsp_flag_we,
  input wire opdec_pkg::dsp_flags_t dsp_flag_in,
  output logic dec_valid,
  output opdec_pkg::dec_out_t dec,
  output opdec_pkg::mcu_flags_t mcu_flags,
  output opdec_pkg::dsp_flags_t dsp_flags
);

  typedef struct packed {
    opdec_pkg::dec_out_t dec;
    opdec_pkg::mcu_flags_t mcu;
    opdec_pkg::dsp_flags_t dsp;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic x_bad;
  logic y_bad;
  logic [3:0] x_reg_sel;
  logic [3:0] y_reg_sel;

  // ==========================================================
  // Multiply pair table
  // ==========================================================
  // Codes 0..5 map to the six distinct pairs; others are illegal.
  function automatic logic [8:0] pair_lookup(input logic [3:0] code);
    begin
      case (code)
        4'h0: pair_lookup = {1'b1, 4'h4, 4'h5};
        4'h1: pair_lookup = {1'b1, 4'h4, 4'h6};
        4'h2: pair_lookup = {1'b1, 4'h4, 4'h7};
        4'h3: pair_lookup = {1'b1, 4'h5, 4'h6};
        4'h4: pair_lookup = {1'b1, 4'h5, 4'h7};
        4'h5: pair_lookup = {1'b1, 4'h6, 4'h7};
        default: pair_lookup = {1'b0, 4'h0, 4'h0};
      endcase
    end
  endfunction

  // ==========================================================
  // Prefetch operand checks
  // ==========================================================
  prefetch_check u_x_check (
    .mode(req.x_mode),
    .reg_hi(req.x_reg),
    .step(req.x_step),
    .dest(req.x_dest),
    .base_lo(opdec_pkg::REG_W8),
    .addr_reg(x_reg_sel),
    .bad(x_bad)
  );

  prefetch_check u_y_check (
    .mode(req.y_mode),
    .reg_hi(req.y_reg),
    .step(req.y_step),
    .dest(req.y_dest),
    .base_lo(opdec_pkg::REG_W10),
    .addr_reg(y_reg_sel),
    .bad(y_bad)
  );

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    logic [8:0] pair;
    logic [2:0] cyc;
    logic ill;
    pair = 9'h000;
    cyc = 3'h0;
    ill = 1'b0;
    s_d = s_q;
    s_d.dec.valid = req.valid;

    if (req.valid)
    begin
      s_d.dec.opcode =
        req.word[opdec_pkg::OPC_MSB:opdec_pkg::OPC_LSB];
      s_d.dec.nop = req.second_word &&
        (req.word[opdec_pkg::OPC_MSB:opdec_pkg::OPC_LSB] ==
         opdec_pkg::OPC_NOP_WORD2);
      s_d.dec.size = req.size;

      s_d.dec.acc_b_sel = req.acc_sel;

      s_d.dec.acc_writeback_dest = opdec_pkg::REG_W13;
      s_d.dec.awb_post_inc = (req.awb_en && req.awb_indirect) ?
        opdec_pkg::AWB_STEP : 4'h0;

      s_d.dec.bit_mask = 16'h0001 << req.bit_select_field;

      if (req.size == opdec_pkg::SZ_BYTE &&
          req.ten_bit_literal > opdec_pkg::BYTE_LIT_MAX)
      begin
        ill = 1'b1;
      end

      if (req.program_addr_literal[0])
      begin
        ill = 1'b1;
      end
      // The address keeps its value with the low bit forced even.
      s_d.dec.prog_addr =
        {1'b0, req.program_addr_literal[22:1], 1'b0};

      s_d.dec.file_op_work_reg = opdec_pkg::REG_W0;

      if (req.mult_square)
      begin
        s_d.dec.mul_a = opdec_pkg::REG_W4 + {2'b00, req.sq_reg};
        s_d.dec.mul_b = opdec_pkg::REG_W4 + {2'b00, req.sq_reg};
      end
      else
      begin
        pair = pair_lookup(req.dsp_mult_pair);
        s_d.dec.mul_a = pair[7:4];
        s_d.dec.mul_b = pair[3:0];
        if (!pair[8])
        begin
          ill = 1'b1;
        end
      end

      s_d.dec.x_prefetch_addr = x_reg_sel;
      s_d.dec.y_prefetch_addr = y_reg_sel;
      if (x_bad || y_bad)
      begin
        ill = 1'b1;
      end

      if (req.div_indirect)
      begin
        ill = 1'b1;
      end

      cyc = opdec_pkg::BASE_CYCLES;
      if (req.skip_taken)
      begin
        cyc = cyc + (req.skip_two_word ? opdec_pkg::SKIP2_EXTRA :
                     opdec_pkg::SKIP1_EXTRA);
      end
      if (req.dword_move)
      begin
        cyc = cyc + opdec_pkg::DMOV_EXTRA;
      end
      if (req.sfr_access)
      begin
        cyc = cyc + opdec_pkg::SFR_EXTRA;
      end
      s_d.dec.cycles = cyc;
      s_d.dec.illegal = ill;
    end

    if (mcu_flag_we)
    begin
      s_d.mcu.c = mcu_flag_in.c;
      s_d.mcu.digit_carry_flag = mcu_flag_in.digit_carry_flag;
      s_d.mcu.n = mcu_flag_in.n;
      s_d.mcu.overflow_flag = mcu_flag_in.overflow_flag;
      // Zero only clears; a zero result never sets it again.
      s_d.mcu.z = s_q.mcu.z & mcu_flag_in.z;
    end
    if (dsp_flag_we)
    begin
      s_d.dsp = dsp_flag_in;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign dec_valid = s_q.dec.valid;
  assign dec = s_q.dec;
  assign mcu_flags = s_q.mcu;
  assign dsp_flags = s_q.dsp;

endmodule
`default_nettype wire

// ---- rtl/opdec_pkg.sv ----
// Constants, types and field layouts for the operand decoder.
// Contract
// - Taken skip costs two or three cycles
// - Double-word move takes two cycles
// - Peripheral register read adds one cycle
// - Write-back is W13 or [W13]+=2
// - Bit select is 4 bits, 0..15
// - Ten-bit literal capped at 255 for bytes
// - Program address literal must be even
// - Keep five MCU flags, zero sticky
// - Keep overflow and saturate per accumulator
// - Accumulator operand selects A or B
// - File working destination is W0
// - Square register is one of W4..W7
// - Multiply pairs: six distinct W4..W7 pairs
// - X prefetch from W8/W9 allowed forms
// - Y prefetch from W10/W11 allowed forms
// - Prefetch destination is W4..W7
// - Divide operands are direct registers
// - Size defaults to word
// - Instruction is 24 bits, 8-bit opcode
// - Zero-topped second word acts as no-op
package opdec_pkg;

  localparam int INSTR_W = 24;
  localparam int OPC_MSB = 23;
  localparam int OPC_LSB = 16;
  localparam logic [7:0] OPC_NOP_WORD2 = 8'h00;

  localparam logic [3:0] REG_W0 = 4'h0;
  localparam logic [3:0] REG_W4 = 4'h4;
  localparam logic [3:0] REG_W7 = 4'h7;
  localparam logic [3:0] REG_W8 = 4'h8;
  localparam logic [3:0] REG_W9 = 4'h9;
  localparam logic [3:0] REG_W10 = 4'hA;
  localparam logic [3:0] REG_W11 = 4'hB;
  localparam logic [3:0] REG_W12 = 4'hC;
  localparam logic [3:0] REG_W13 = 4'hD;
  localparam logic [3:0] REG_W14 = 4'hE;

  localparam logic [9:0] BYTE_LIT_MAX = 10'h0FF;
  localparam logic [3:0] AWB_STEP = 4'h2;
  localparam logic [2:0] PF_STEP_MAX = 3'h3;

  localparam logic [2:0] BASE_CYCLES = 3'h1;
  localparam logic [2:0] SKIP1_EXTRA = 3'h1;
  localparam logic [2:0] SKIP2_EXTRA = 3'h2;
  localparam logic [2:0] SFR_EXTRA = 3'h1;
  localparam logic [2:0] DMOV_EXTRA = 3'h1;

  // Operand size suffix.
  typedef enum logic [1:0] {
    SZ_WORD = 2'h0,
    SZ_BYTE = 2'h1,
    SZ_DWORD = 2'h2,
    SZ_SHADOW = 2'h3
  } size_t;

  // Prefetch mode: 0 none, 1 plain, 2 post-inc, 3 post-dec, 4 offset W12.
  typedef enum logic [2:0] {
    PF_NONE = 3'h0,
    PF_PLAIN = 3'h1,
    PF_INC = 3'h2,
    PF_DEC = 3'h3,
    PF_OFS = 3'h4
  } pf_mode_t;

  typedef struct packed {
    logic valid;
    logic [23:0] word;
    logic second_word;
    size_t size;
    logic acc_sel;
    logic awb_en;
    logic awb_indirect;
    logic [3:0] bit_select_field;
    logic [9:0] ten_bit_literal;
    logic [22:0] program_addr_literal;
    logic file_to_file_op_work_reg;
    logic [1:0] sq_reg;
    logic [3:0] dsp_mult_pair;
    logic mult_square;
    pf_mode_t x_mode;
    logic x_reg;
    logic [1:0] x_step;
    logic [3:0] x_dest;
    pf_mode_t y_mode;
    logic y_reg;
    logic [1:0] y_step;
    logic [3:0] y_dest;
    logic div_indirect;
    logic [3:0] div_dividend;
    logic [3:0] div_divisor;
    logic skip_taken;
    logic skip_two_word;
    logic dword_move;
    logic sfr_access;
  } instr_req_t;

  typedef struct packed {
    logic c;
    logic digit_carry_flag;
    logic n;
    logic overflow_flag;
    logic z;
  } mcu_flags_t;

  typedef struct packed {
    logic acc_a_overflow;
    logic acc_b_overflow;
    logic acc_a_saturate;
    logic acc_b_saturate;
  } dsp_flags_t;

  typedef struct packed {
    logic valid;
    logic illegal;
    logic nop;
    logic [7:0] opcode;
    logic [2:0] cycles;
    logic [3:0] acc_writeback_dest;
    logic [3:0] awb_post_inc;
    logic acc_b_sel;
    logic [3:0] file_op_work_reg;
    logic [15:0] bit_mask;
    logic [23:0] prog_addr;
    logic [3:0] mul_a;
    logic [3:0] mul_b;
    logic [3:0] x_prefetch_addr;
    logic [3:0] y_prefetch_addr;
    size_t size;
  } dec_out_t;

endpackage

// ---- rtl/prefetch_check.sv ----
// Checks one prefetch address operand and its destination register.
`timescale 1ns/100ps
`default_nettype none
module prefetch_check (
  input wire opdec_pkg::pf_mode_t mode,
  input wire logic reg_hi,
  input wire logic [1:0] step,
  input wire logic [3:0] dest,
  input wire logic [3:0] base_lo,
  output logic [3:0] addr_reg,
  output logic bad
);

  // The offset form exists only on the upper base register.
  always_comb
  begin
    addr_reg = reg_hi ? base_lo + 4'h1 : base_lo;
    bad = 1'b0;
    case (mode)
      opdec_pkg::PF_NONE: bad = 1'b0;
      opdec_pkg::PF_PLAIN: bad = 1'b0;
      opdec_pkg::PF_INC, opdec_pkg::PF_DEC:
        bad = (step == 2'h0);
      opdec_pkg::PF_OFS: bad = !reg_hi;
      default: bad = 1'b1;
    endcase
    if (mode != opdec_pkg::PF_NONE &&
        (dest < opdec_pkg::REG_W4 || dest > opdec_pkg::REG_W7))
    begin
      bad = 1'b1;
    end
  end

endmodule
`default_nettype wire

// ---- verification/operand_decode_asserts.sv ----
// Concurrent checks on the operand decoder ports.
`timescale 1ns/100ps
`default_nettype none
module operand_decode_asserts (
  input wire logic mclk,
  input wire logic reset_n,
  input wire opdec_pkg::instr_req_t req,
  input wire logic mcu_flag_we,
  input wire opdec_pkg::mcu_flags_t mcu_flag_in,
  input wire logic dsp_flag_we,
  input wire opdec_pkg::dsp_flags_t dsp_flag_in,
  input wire logic dec_valid,
  input wire opdec_pkg::dec_out_t dec,
  input wire opdec_pkg::mcu_flags_t mcu_flags,
  input wire opdec_pkg::dsp_flags_t dsp_flags
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_skip_one;
    req.valid && req.skip_taken && !req.skip_two_word;
  endsequence
  sequence s_skip_sfr;
    s_skip_one ##0 (req.sfr_access && !req.dword_move);
  endsequence
  property p_answer; req.valid |=> dec_valid; endproperty
  a_answer: assert property (p_answer)
    else $error("decode result missing");
  property p_skip;
    s_skip_one ##0 !(req.sfr_access || req.dword_move) |=> dec.cycles == 2'h2;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip cycle count wrong");
  property p_sum; s_skip_sfr |=> dec.cycles == 2'h3; endproperty
  a_sum: assert property (p_sum)
    else $error("penalties do not add");
  property p_dmov;
    req.valid && req.dword_move && !req.skip_taken && !req.sfr_access
      |=> dec.cycles == 2'h2;
  endproperty
  a_dmov: assert property (p_dmov)
    else $error("double move cycle count wrong");
  property p_awb; dec_valid |-> dec.acc_writeback_dest == 4'hD; endproperty
  a_awb: assert property (p_awb)
    else $error("write-back register wrong");
  property p_lit;
    req.valid && req.size == opdec_pkg::SZ_BYTE &&
      req.ten_bit_literal > 10'h0FF |=> dec.illegal;
  endproperty
  a_lit: assert property (p_lit)
    else $error("byte literal overflow accepted");
  property p_odd; req.valid && req.program_addr_literal[0] |=> dec.illegal;
  endproperty
  a_odd: assert property (p_odd)
    else $error("odd program address accepted");
  property p_nop;
    req.valid && req.second_word && req.word[23:16] == 8'h00 |=> dec.nop;
  endproperty
  a_nop: assert property (p_nop)
    else $error("second word not a no-op");
  property p_zero; !mcu_flags.z |=> !mcu_flags.z; endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag set again");
  property p_pair;
    req.valid && !req.mult_square && req.dsp_mult_pair > 4'h5 |=> dec.illegal;
  endproperty
  a_pair: assert property (p_pair)
    else $error("bad multiply pair accepted");
endmodule
bind operand_decode operand_decode_asserts u_chk (.mclk(mclk),
  .reset_n(reset_n), .req(req), .mcu_flag_we(mcu_flag_we),
  .mcu_flag_in(mcu_flag_in), .dsp_flag_we(dsp_flag_we),
  .dsp_flag_in(dsp_flag_in), .dec_valid(dec_valid), .dec(dec),
  .mcu_flags(mcu_flags), .dsp_flags(dsp_flags));
`default_nettype wire

// ---- verification/operand_decode_test.sv ----
// Self-checking bench for the operand decoder.
`timescale 1ns/100ps
`default_nettype none
module operand_decode_test;
  logic mclk;
  logic reset_n;
  logic mcu_flag_we;
  logic dsp_flag_we;
  logic dec_valid;
  opdec_pkg::instr_req_t req;
  opdec_pkg::instr_req_t r;
  opdec_pkg::mcu_flags_t mcu_flag_in;
  opdec_pkg::mcu_flags_t mcu_flags;
  opdec_pkg::dsp_flags_t dsp_flag_in;
  opdec_pkg::dsp_flags_t dsp_flags;
  opdec_pkg::dec_out_t dec;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  // Row: skip taken, skip two-word, double move, peripheral, cycles.
  logic [5:0] rows [6] = '{6'h01, 6'h22, 6'h33, 6'h0A, 6'h06, 6'h27};
  logic [7:0] pairs [6] = '{8'h45, 8'h46, 8'h47, 8'h56, 8'h57, 8'h67};
  operand_decode DUT (.mclk(mclk), .reset_n(reset_n), .req(req),
    .mcu_flag_we(mcu_flag_we), .mcu_flag_in(mcu_flag_in),
    .dsp_flag_we(dsp_flag_we), .dsp_flag_in(dsp_flag_in),
    .dec_valid(dec_valid), .dec(dec), .mcu_flags(mcu_flags),
    .dsp_flags(dsp_flags));
  // ==========================================================
  // Clock, timeout and helpers
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [23:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic opdec_pkg::instr_req_t base();
    base = '0;
    base.valid = 1'b1;
    base.word = 24'h12_3456;
  endfunction
  task automatic go(input opdec_pkg::instr_req_t q);
    @(posedge mclk);
    req <= q;
    @(posedge mclk);
    req.valid <= 1'b0;
    #1;
    chk("dec_valid", dec_valid, 1'b1);
  endtask
  task automatic bad(input opdec_pkg::instr_req_t q, input logic exp);
    go(q);
    chk("illegal", dec.illegal, exp);
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Stimulus
  initial
  begin
    reset_n = 1'b0;
    req = '0;
    mcu_flag_we = 1'b0;
    dsp_flag_we = 1'b0;
    mcu_flag_in = '0;
    dsp_flag_in = '0;
    repeat (5) @(posedge mclk);
    chk("dec_valid", dec_valid, 1'b0);
    reset_n <= 1'b1;
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      r = base();
      {r.skip_taken, r.skip_two_word, r.dword_move, r.sfr_access} =
        rows[i][5:2];
      go(r);
      chk("cyc", dec.cycles, rows[i][1:0]);
    end
    r = base();
    r.skip_taken = 1'b1;
    r.skip_two_word = 1'b1;
    r.sfr_access = 1'b1;
    go(r);
    chk("cyc", dec.cycles, 3'h4);
    for (int i = 0; i < 7; i++)
    begin
      r = base();
      r.dsp_mult_pair = 4'(i);
      bad(r, i == 6);
      if (i < 6)
        chk("pair", {dec.mul_a, dec.mul_b}, pairs[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      r = base();
      r.mult_square = 1'b1;
      r.sq_reg = 2'(i);
      go(r);
      chk("square", {dec.mul_a, dec.mul_b}, {2{4'(i + 4)}});
    end
    $display("table tests done");
    r = base();
    r.x_mode = opdec_pkg::PF_OFS;
    r.x_dest = 4'h4;
    bad(r, 1'b1);
    r.x_mode = opdec_pkg::PF_INC;
    r.x_reg = 1'b1;
    bad(r, 1'b1);
    r.x_step = 2'h3;
    r.x_dest = 4'h7;
    bad(r, 1'b0);
    chk("x_addr", dec.x_prefetch_addr, 4'h9);
    chk("size", dec.size, opdec_pkg::SZ_WORD);
    r = base();
    r.y_mode = opdec_pkg::PF_DEC;
    r.y_step = 2'h1;
    r.y_dest = 4'h3;
    bad(r, 1'b1);
    r.y_mode = opdec_pkg::PF_OFS;
    r.y_reg = 1'b1;
    r.y_dest = 4'h5;
    bad(r, 1'b0);
    chk("y_addr", dec.y_prefetch_addr, 4'hB);
    r = base();
    r.size = opdec_pkg::SZ_BYTE;
    r.ten_bit_literal = 10'h100;
    bad(r, 1'b1);
    r.size = opdec_pkg::SZ_WORD;
    r.ten_bit_literal = 10'h3FF;
    bad(r, 1'b0);
    r.program_addr_literal = 23'h00_0001;
    bad(r, 1'b1);
    r = base();
    r.div_indirect = 1'b1;
    bad(r, 1'b1);
    r.div_indirect = 1'b0;
    r.program_addr_literal = 23'h40_0002;
    for (int i = 0; i < 6; i++)
    begin
      bad(r, 1'b0);
    end
    chk("prog_addr", dec.prog_addr, 24'h40_0002);
    r = base();
    r.word = 24'h00_1234;
    r.second_word = 1'b1;
    r.awb_en = 1'b1;
    r.awb_indirect = 1'b1;
    r.bit_select_field = 4'hF;
    r.file_to_file_op_work_reg = 1'b1;
    r.acc_sel = 1'b1;
    r.size = opdec_pkg::SZ_DWORD;
    go(r);
    chk("nop", {dec.nop, dec.opcode}, 9'h100);
    chk("awb", {dec.acc_writeback_dest, dec.awb_post_inc}, 8'hD2);
    chk("bit_mask", dec.bit_mask, 16'h8000);
    chk("file_op_work_reg", dec.file_op_work_reg, 4'h0);
    chk("acc_b", dec.acc_b_sel, 1'b1);
    chk("size", dec.size, opdec_pkg::SZ_DWORD);
    @(posedge mclk);
    mcu_flag_we <= 1'b1;
    mcu_flag_in <= 5'h1F;
    dsp_flag_we <= 1'b1;
    dsp_flag_in <= 4'hA;
    @(posedge mclk);
    mcu_flag_we <= 1'b0;
    dsp_flag_we <= 1'b0;
    #1;
    chk("mcu_flags", mcu_flags, 5'h1E);
    chk("dsp_flags", dsp_flags, 4'hA);
    $display("field and flag tests done");
    give_verdict();
  end
endmodule
`default_nettype wire
